// ---- rtl/lcsr_defines.svh ----
// constants for the control and system register load decoder
`ifndef LCSR_DEFINES_SVH
`define LCSR_DEFINES_SVH
`define LCSR_STATUS_MASK     32'h700083F3
`define LCSR_FLOAT_CTL_MASK  32'h003FFFFF
`define LCSR_POST_INC        32'h00000004
`define LCSR_PC_STEP         32'h00000002
`define LCSR_GROUP_NIBBLE    4'h4
`define LCSR_T_BIT           0
`define LCSR_MODE_BIT        30
`define LCSR_BANK_BIT        29
`define LCSR_STATES_STATUS   3'h4
`define LCSR_STATES_GBASE    3'h3
`define LCSR_STATES_LINK     3'h2
`define LCSR_STATES_ONE      3'h1
`define LCSR_STATUS_RESET    32'h700000F0
`define LCSR_ZERO_WORD       32'h00000000
`endif

// ---- rtl/lcsr_pkg.sv ----
// types for the control and system register load decoder
package lcsr_pkg;
  typedef enum logic [3:0] {
    LCSR_TGT_NONE, LCSR_TGT_STATUS, LCSR_TGT_GBASE, LCSR_TGT_VBASE, LCSR_TGT_SSTAT,
    LCSR_TGT_SPC, LCSR_TGT_DBASE, LCSR_TGT_SHADOW, LCSR_TGT_FLOAT_XFER,
    LCSR_TGT_FLOAT_CTL, LCSR_TGT_ACC_HI, LCSR_TGT_ACC_LO, LCSR_TGT_LINK
  } lcsr_target_t;
  typedef enum logic [2:0] {
    LCSR_EXC_NONE, LCSR_EXC_ILLEGAL, LCSR_EXC_SLOT, LCSR_EXC_TLB_MISS,
    LCSR_EXC_TLB_PROT, LCSR_EXC_ADDR
  } lcsr_exc_t;
endpackage

// ---- rtl/lcsr_decode.sv ----
// opcode decoder for the control and system register loads
`timescale 1ns/10ps
`include "lcsr_defines.svh"
module lcsr_decode (
  input  wire logic [15:0]          opcode,    // instruction word
  output lcsr_pkg::lcsr_target_t    target,    // register loaded
  output logic                      is_mem,    // memory post-increment form
  output logic                      is_priv,   // privileged form
  output logic [2:0]                states,    // execution states
  output logic [2:0]                bank_idx   // shadow register index
);
  wire grp = opcode[15:12] == `LCSR_GROUP_NIBBLE;
  wire [7:0] lo = opcode[7:0];
  wire shadow_reg = grp && lo[7] && lo[3:0] == 4'hE;
  wire shadow_mem = grp && lo[7] && lo[3:0] == 4'h7;
  assign bank_idx = lo[6:4];
  always_comb begin
    target = lcsr_pkg::LCSR_TGT_NONE;
    is_mem = 1'b0;
    if (shadow_reg || shadow_mem) begin
      target = lcsr_pkg::LCSR_TGT_SHADOW;
      is_mem = shadow_mem;
    end else if (grp) begin
      unique case (lo)
        8'h0E: target = lcsr_pkg::LCSR_TGT_STATUS;
        8'h07: begin target = lcsr_pkg::LCSR_TGT_STATUS; is_mem = 1'b1; end
        8'h1E: target = lcsr_pkg::LCSR_TGT_GBASE;
        8'h17: begin target = lcsr_pkg::LCSR_TGT_GBASE; is_mem = 1'b1; end
        8'h2E: target = lcsr_pkg::LCSR_TGT_VBASE;
        8'h3E: target = lcsr_pkg::LCSR_TGT_SSTAT;
        8'h4E: target = lcsr_pkg::LCSR_TGT_SPC;
        8'h27: begin target = lcsr_pkg::LCSR_TGT_VBASE; is_mem = 1'b1; end
        8'h37: begin target = lcsr_pkg::LCSR_TGT_SSTAT; is_mem = 1'b1; end
        8'h47: begin target = lcsr_pkg::LCSR_TGT_SPC; is_mem = 1'b1; end
        8'hFA: target = lcsr_pkg::LCSR_TGT_DBASE;
        8'hF6: begin target = lcsr_pkg::LCSR_TGT_DBASE; is_mem = 1'b1; end
        8'h5A: target = lcsr_pkg::LCSR_TGT_FLOAT_XFER;
        8'h56: begin target = lcsr_pkg::LCSR_TGT_FLOAT_XFER; is_mem = 1'b1; end
        8'h6A: target = lcsr_pkg::LCSR_TGT_FLOAT_CTL;
        8'h66: begin target = lcsr_pkg::LCSR_TGT_FLOAT_CTL; is_mem = 1'b1; end
        8'h0A: target = lcsr_pkg::LCSR_TGT_ACC_HI;
        8'h1A: target = lcsr_pkg::LCSR_TGT_ACC_LO;
        8'h06: begin target = lcsr_pkg::LCSR_TGT_ACC_HI; is_mem = 1'b1; end
        8'h16: begin target = lcsr_pkg::LCSR_TGT_ACC_LO; is_mem = 1'b1; end
        8'h2A: target = lcsr_pkg::LCSR_TGT_LINK;
        8'h26: begin target = lcsr_pkg::LCSR_TGT_LINK; is_mem = 1'b1; end
        default: target = lcsr_pkg::LCSR_TGT_NONE;
      endcase
    end
  end
  // only control loads other than the global base are privileged
  assign is_priv = target == lcsr_pkg::LCSR_TGT_STATUS || target == lcsr_pkg::LCSR_TGT_VBASE
                || target == lcsr_pkg::LCSR_TGT_SSTAT || target == lcsr_pkg::LCSR_TGT_SPC
                || target == lcsr_pkg::LCSR_TGT_DBASE || target == lcsr_pkg::LCSR_TGT_SHADOW;
  assign states = target == lcsr_pkg::LCSR_TGT_STATUS ? `LCSR_STATES_STATUS :
                  target == lcsr_pkg::LCSR_TGT_GBASE  ? `LCSR_STATES_GBASE :
                  target == lcsr_pkg::LCSR_TGT_LINK   ? `LCSR_STATES_LINK : `LCSR_STATES_ONE;
endmodule // lcsr_decode

// ---- rtl/lcsr_core.sv ----
// executes the control and system register load instructions
//
// Behaviour
// - register to status word is masked by 700083F3, T taken from source bit 0, four states
// - memory to status word reads a longword, same mask, source plus four
// - global base pointer loads copy unmasked in three states, both forms
// - all control loads but global base are privileged; user mode is illegal
// - both global base pointer loads run in user mode without exception
// - shadow loads hit bank 0 when bank select is 1, bank 1 otherwise
// - shadow loads from register decode as 0100 mmmm 1nnn 1110, one state
// - shadow loads from memory decode as 0100 mmmm 1nnn 0111, post-increment
// - debug base pointer loads, register and memory, one state, unmasked
// - vector base, saved status, saved pc register loads, one state
// - vector base, saved status, saved pc memory loads with post-increment
// - control loads but global base can raise slot illegal; memory forms TLB and address errors
// - float transfer word loads unmasked, register or memory, one state
// - float control register load keeps bits of mask 003FFFFF, rest zero
// - float control memory load applies the same mask, source plus four
// - accumulator high and low register loads copy full word, one state
// - accumulator high and low memory loads with post-increment
// - return link loads take two states, register or memory
// - float system memory loads can raise TLB miss, protection, address error
`timescale 1ns/10ps
`include "lcsr_defines.svh"
module lcsr_core (
  input  wire logic        CORE_CLK,        // core clock
  input  wire logic        RST,             // synchronous reset, active high
  input  wire logic        CLK_EN,          // clock enable, freezes state when low
  input  wire logic        ISSUE_VALID,     // instruction offered
  output logic             ISSUE_READY,     // decoder can take an instruction
  input  wire logic [15:0] OPCODE,          // instruction word
  input  wire logic        IN_DELAY_SLOT,   // instruction sits in a delay slot
  input  wire logic [31:0] SRC_GENERAL_REG, // value of the source general register
  output logic [3:0]       SRC_INDEX,       // index of the source general register
  output logic             MEM_REQ,         // longword read request
  output logic [31:0]      MEM_ADDR,        // read address
  input  wire logic        MEM_ACK,         // read done
  input  wire logic [31:0] MEM_RDATA,       // read data
  input  wire logic        MEM_TLB_MISS,    // data tlb miss on read
  input  wire logic        MEM_TLB_PROT,    // data protection violation on read
  output logic             RM_WE,           // write back incremented source
  output logic [31:0]      RM_WDATA,        // incremented source value
  output logic             SHADOW_WE,       // shadow register write
  output logic [2:0]       SHADOW_IDX,      // shadow register index
  output logic             SHADOW_BANK,     // bank written
  output logic [31:0]      SHADOW_WDATA,    // shadow register data
  output logic [31:0]      STATUS_WORD,     // status word
  output logic [31:0]      GLOBAL_BASE,     // global base pointer
  output logic [31:0]      VECTOR_BASE,     // vector base pointer
  output logic [31:0]      SAVED_STATUS,    // saved status copy
  output logic [31:0]      SAVED_PC,        // saved program counter
  output logic [31:0]      DEBUG_BASE,      // debug base pointer
  output logic [31:0]      FLOAT_XFER,      // float transfer word
  output logic [31:0]      FLOAT_CTL,       // float status and control
  output logic [31:0]      ACCUM_HIGH,      // accumulator high word
  output logic [31:0]      ACCUM_LOW,       // accumulator low word
  output logic [31:0]      RETURN_LINK,     // subroutine return link
  input  wire logic [31:0] PC_IN,           // current program counter
  output logic             PC_WE,           // program counter advance
  output logic [31:0]      PC_NEXT,         // next program counter
  output logic             DONE,            // instruction retired, one cycle
  output logic             EXC_VALID,       // exception raised, one cycle
  output lcsr_pkg::lcsr_exc_t EXC_CODE      // exception kind
);
  typedef enum logic [1:0] { LCSR_S_IDLE, LCSR_S_MEM, LCSR_S_EXEC } lcsr_state_t;
  lcsr_state_t state_reg;
  lcsr_pkg::lcsr_target_t dec_target, target_reg;
  logic        dec_mem, dec_priv;
  logic [2:0]  dec_states, dec_bank, bank_reg, cnt_reg;
  logic [31:0] value_reg, src_reg;
  logic        mem_reg;
  lcsr_decode u_decode (
    .opcode   (OPCODE),
    .target   (dec_target),
    .is_mem   (dec_mem),
    .is_priv  (dec_priv),
    .states   (dec_states),
    .bank_idx (dec_bank)
  );
  wire user_mode  = ~STATUS_WORD[`LCSR_MODE_BIT];
  wire take       = CLK_EN && state_reg == LCSR_S_IDLE && ISSUE_VALID;
  wire known      = dec_target != lcsr_pkg::LCSR_TGT_NONE;
  wire illegal    = dec_priv && user_mode;
  wire slot_bad   = dec_priv && IN_DELAY_SLOT;
  wire addr_bad   = dec_mem && SRC_GENERAL_REG[1:0] != 2'b00;
  wire start_ok   = take && known && !illegal && !slot_bad && !addr_bad;
  wire mem_done   = CLK_EN && state_reg == LCSR_S_MEM && MEM_ACK;
  wire mem_fault  = mem_done && (MEM_TLB_MISS || MEM_TLB_PROT);
  wire finish     = CLK_EN && state_reg == LCSR_S_EXEC && cnt_reg == 3'h1;
  wire [31:0] src_inc = src_reg + `LCSR_POST_INC;
  assign ISSUE_READY = state_reg == LCSR_S_IDLE;
  assign SRC_INDEX   = OPCODE[11:8];
  assign MEM_REQ     = state_reg == LCSR_S_MEM;
  assign MEM_ADDR    = src_reg;
  // load value steered to its register on the final state
  wire [31:0] status_new = value_reg & `LCSR_STATUS_MASK;
  wire [31:0] fctl_new   = value_reg & `LCSR_FLOAT_CTL_MASK;
  wire wr = finish;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_reg  <= LCSR_S_IDLE;
      target_reg <= lcsr_pkg::LCSR_TGT_NONE;
      bank_reg   <= 3'h0;
      cnt_reg    <= 3'h0;
      value_reg  <= `LCSR_ZERO_WORD;
      src_reg    <= `LCSR_ZERO_WORD;
      mem_reg    <= 1'b0;
    end else if (CLK_EN) begin
      unique case (state_reg)
        LCSR_S_IDLE: if (start_ok) begin
          target_reg <= dec_target;
          bank_reg   <= dec_bank;
          cnt_reg    <= dec_states;
          src_reg    <= SRC_GENERAL_REG;
          value_reg  <= SRC_GENERAL_REG;
          mem_reg    <= dec_mem;
          state_reg  <= dec_mem ? LCSR_S_MEM : LCSR_S_EXEC;
        end
        LCSR_S_MEM: if (MEM_ACK) begin
          value_reg <= MEM_RDATA;
          state_reg <= mem_fault ? LCSR_S_IDLE : LCSR_S_EXEC;
        end
        LCSR_S_EXEC: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) state_reg <= LCSR_S_IDLE;
        end
        default: state_reg <= LCSR_S_IDLE;
      endcase
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      STATUS_WORD  <= `LCSR_STATUS_RESET;
      GLOBAL_BASE  <= `LCSR_ZERO_WORD;
      VECTOR_BASE  <= `LCSR_ZERO_WORD;
      SAVED_STATUS <= `LCSR_ZERO_WORD;
      SAVED_PC     <= `LCSR_ZERO_WORD;
      DEBUG_BASE   <= `LCSR_ZERO_WORD;
      FLOAT_XFER   <= `LCSR_ZERO_WORD;
      FLOAT_CTL    <= `LCSR_ZERO_WORD;
      ACCUM_HIGH   <= `LCSR_ZERO_WORD;
      ACCUM_LOW    <= `LCSR_ZERO_WORD;
      RETURN_LINK  <= `LCSR_ZERO_WORD;
    end else if (CLK_EN && wr) begin
      unique case (target_reg)
        lcsr_pkg::LCSR_TGT_STATUS:     STATUS_WORD  <= status_new;
        lcsr_pkg::LCSR_TGT_GBASE:      GLOBAL_BASE  <= value_reg;
        lcsr_pkg::LCSR_TGT_VBASE:      VECTOR_BASE  <= value_reg;
        lcsr_pkg::LCSR_TGT_SSTAT:      SAVED_STATUS <= value_reg;
        lcsr_pkg::LCSR_TGT_SPC:        SAVED_PC     <= value_reg;
        lcsr_pkg::LCSR_TGT_DBASE:      DEBUG_BASE   <= value_reg;
        lcsr_pkg::LCSR_TGT_FLOAT_XFER: FLOAT_XFER   <= value_reg;
        lcsr_pkg::LCSR_TGT_FLOAT_CTL:  FLOAT_CTL    <= fctl_new;
        lcsr_pkg::LCSR_TGT_ACC_HI:     ACCUM_HIGH   <= value_reg;
        lcsr_pkg::LCSR_TGT_ACC_LO:     ACCUM_LOW    <= value_reg;
        lcsr_pkg::LCSR_TGT_LINK:       RETURN_LINK  <= value_reg;
        default: ;
      endcase
    end
  end
  // shadow write uses the bank opposite the selected one
  assign SHADOW_WE    = wr && target_reg == lcsr_pkg::LCSR_TGT_SHADOW;
  assign SHADOW_IDX   = bank_reg;
  assign SHADOW_BANK  = ~STATUS_WORD[`LCSR_BANK_BIT];
  assign SHADOW_WDATA = value_reg;
  assign RM_WE        = wr && mem_reg;
  assign RM_WDATA     = src_inc;
  assign PC_WE        = wr;
  assign PC_NEXT      = PC_IN + `LCSR_PC_STEP;
  assign DONE         = wr;
  always_comb begin
    EXC_VALID = 1'b0;
    EXC_CODE  = lcsr_pkg::LCSR_EXC_NONE;
    if (take && known && illegal) begin
      EXC_VALID = 1'b1;
      EXC_CODE  = IN_DELAY_SLOT ? lcsr_pkg::LCSR_EXC_SLOT : lcsr_pkg::LCSR_EXC_ILLEGAL;
    end else if (take && known && slot_bad) begin
      EXC_VALID = 1'b1;
      EXC_CODE  = lcsr_pkg::LCSR_EXC_SLOT;
    end else if (take && known && addr_bad) begin
      EXC_VALID = 1'b1;
      EXC_CODE  = lcsr_pkg::LCSR_EXC_ADDR;
    end else if (mem_fault) begin
      EXC_VALID = 1'b1;
      EXC_CODE  = MEM_TLB_MISS ? lcsr_pkg::LCSR_EXC_TLB_MISS : lcsr_pkg::LCSR_EXC_TLB_PROT;
    end
  end

  sequence s_status_reg_start;
    start_ok && OPCODE[7:0] == 8'h0E;
  endsequence
  a_status_four_states: assert property (@(posedge CORE_CLK) disable iff (RST || !CLK_EN)
    s_status_reg_start |=> !DONE [*3] ##1 DONE) else $error("status load not four states");
  a_status_masked: assert property (@(posedge CORE_CLK) disable iff (RST)
    (STATUS_WORD & ~`LCSR_STATUS_MASK) == 32'h00000000 || STATUS_WORD == `LCSR_STATUS_RESET)
    else $error("status word has masked bits");
  a_gbase_three_states: assert property (@(posedge CORE_CLK) disable iff (RST || !CLK_EN)
    start_ok && dec_target == lcsr_pkg::LCSR_TGT_GBASE && !dec_mem |=> !DONE [*2] ##1 DONE)
    else $error("global base load not three states");
  a_user_illegal: assert property (@(posedge CORE_CLK) disable iff (RST)
    take && known && dec_priv && user_mode |-> EXC_VALID && !start_ok) else $error("privileged in user mode");
  a_user_gbase_ok: assert property (@(posedge CORE_CLK) disable iff (RST)
    take && dec_target == lcsr_pkg::LCSR_TGT_GBASE && !dec_mem |-> !EXC_VALID) else $error("gbase refused");
  a_shadow_bank_sel: assert property (@(posedge CORE_CLK) disable iff (RST)
    SHADOW_WE |-> SHADOW_BANK != STATUS_WORD[`LCSR_BANK_BIT]) else $error("wrong shadow bank");
  a_link_two_states: assert property (@(posedge CORE_CLK) disable iff (RST || !CLK_EN)
    start_ok && dec_target == lcsr_pkg::LCSR_TGT_LINK && !dec_mem |=> !DONE ##1 DONE)
    else $error("return link load not two states");
  a_fctl_masked: assert property (@(posedge CORE_CLK) disable iff (RST)
    (FLOAT_CTL & ~`LCSR_FLOAT_CTL_MASK) == 32'h00000000) else $error("float control upper bits set");
  a_post_inc: assert property (@(posedge CORE_CLK) disable iff (RST)
    RM_WE |-> RM_WDATA == MEM_ADDR + 32'h00000004) else $error("post increment wrong");
  a_mem_addr_src: assert property (@(posedge CORE_CLK) disable iff (RST || !CLK_EN)
    start_ok && dec_mem |=> MEM_REQ && MEM_ADDR == $past(SRC_GENERAL_REG)) else $error("read address not source");
  a_fault_no_write: assert property (@(posedge CORE_CLK) disable iff (RST || !CLK_EN)
    mem_fault |=> !DONE && !RM_WE && ISSUE_READY) else $error("write after faulted read");
  a_pc_step: assert property (@(posedge CORE_CLK) disable iff (RST)
    DONE |-> PC_WE && PC_NEXT == PC_IN + 32'h00000002) else $error("pc not advanced");
endmodule // lcsr_core

// ---- testbench/lcsr_mem_model.sv ----
// data memory responder for the longword reads of the load instructions
`timescale 1ns/10ps
module lcsr_mem_model (
  input  wire logic        clk,       // core clock
  input  wire logic        rst,       // synchronous reset
  input  wire logic        mem_req,   // read request from the core
  input  wire logic [31:0] mem_addr,  // read address
  input  wire logic [31:0] word_in,   // word to return, set by the bench
  input  wire logic [1:0]  fault,     // 1 tlb miss, 2 protection, set by the bench
  input  wire logic        slow,      // answer after five waits instead of at once
  output logic             mem_ack,   // read done, one cycle
  output logic [31:0]      mem_rdata, // read data, toggles while not answering
  output logic             tlb_miss,  // miss flag with the answer
  output logic             tlb_prot,  // protection flag with the answer
  output logic [31:0]      seen_addr  // address seen at the answer
);
  logic [3:0] wait_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      mem_rdata <= 32'hA5A5A5A5;
      tlb_miss  <= 1'b0;
      tlb_prot  <= 1'b0;
      seen_addr <= 32'h00000000;
    end else if (mem_ack || !mem_req) begin
      // released bus: no stale word is left for the core to pick up
      mem_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      mem_rdata <= ~mem_rdata;
      tlb_miss  <= 1'b0;
      tlb_prot  <= 1'b0;
    end else if (wait_reg == (slow ? 4'h5 : 4'h0)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= word_in;
      tlb_miss  <= (fault == 2'h1);
      tlb_prot  <= (fault == 2'h2);
      seen_addr <= mem_addr;
    end else begin
      wait_reg  <= wait_reg + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // lcsr_mem_model

// ---- testbench/test_control_system_register_loads.sv ----
// self-checking bench for the control and system register load decoder
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %0s expected %h seen %h", nm, ex, got); end end
module test_control_system_register_loads;
  logic CORE_CLK = 0, RST = 1, CLK_EN = 1, ISSUE_VALID = 0, IN_DELAY_SLOT = 0, SLOW = 0;
  logic [15:0] OPCODE = 16'h0000;
  logic [31:0] SRC_GENERAL_REG = 32'h0, PC_IN = 32'h0, WORD = 32'h0, SEEN, RM_WDATA, SHADOW_WDATA, PC_NEXT;
  logic [31:0] STATUS_WORD, GLOBAL_BASE, VECTOR_BASE, SAVED_STATUS, SAVED_PC, DEBUG_BASE, MEM_ADDR, MEM_RDATA;
  logic [31:0] FLOAT_XFER, FLOAT_CTL, ACCUM_HIGH, ACCUM_LOW, RETURN_LINK, lfsr_q = 32'h9;
  logic [1:0]  FAULT = 2'h0;
  logic [2:0]  SHADOW_IDX;
  logic [3:0]  SRC_INDEX;
  logic MEM_REQ, MEM_ACK, MISS, PROT, RM_WE, SHADOW_WE, SHADOW_BANK, PC_WE, DONE, EXC_VALID, ISSUE_READY;
  lcsr_pkg::lcsr_exc_t EXC_CODE;
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [31:0] exp_reg [13];
  logic [7:0] rlo [13] = '{8'h00, 8'h0E, 8'h1E, 8'h2E, 8'h3E, 8'h4E, 8'hFA, 8'h8E, 8'h5A, 8'h6A, 8'h0A, 8'h1A, 8'h2A};
  logic [7:0] mlo [13] = '{8'h00, 8'h07, 8'h17, 8'h27, 8'h37, 8'h47, 8'hF6, 8'h87, 8'h56, 8'h66, 8'h06, 8'h16, 8'h26};
  lcsr_core dut (.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_READY(ISSUE_READY), .OPCODE(OPCODE), .IN_DELAY_SLOT(IN_DELAY_SLOT), .SRC_GENERAL_REG(SRC_GENERAL_REG),
    .SRC_INDEX(SRC_INDEX), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
    .MEM_TLB_MISS(MISS), .MEM_TLB_PROT(PROT), .RM_WE(RM_WE), .RM_WDATA(RM_WDATA), .SHADOW_WE(SHADOW_WE),
    .SHADOW_IDX(SHADOW_IDX), .SHADOW_BANK(SHADOW_BANK), .SHADOW_WDATA(SHADOW_WDATA), .STATUS_WORD(STATUS_WORD),
    .GLOBAL_BASE(GLOBAL_BASE), .VECTOR_BASE(VECTOR_BASE), .SAVED_STATUS(SAVED_STATUS), .SAVED_PC(SAVED_PC),
    .DEBUG_BASE(DEBUG_BASE), .FLOAT_XFER(FLOAT_XFER), .FLOAT_CTL(FLOAT_CTL), .ACCUM_HIGH(ACCUM_HIGH),
    .ACCUM_LOW(ACCUM_LOW), .RETURN_LINK(RETURN_LINK), .PC_IN(PC_IN), .PC_WE(PC_WE), .PC_NEXT(PC_NEXT),
    .DONE(DONE), .EXC_VALID(EXC_VALID), .EXC_CODE(EXC_CODE));
  lcsr_mem_model mem (.clk(CORE_CLK), .rst(RST), .mem_req(MEM_REQ), .mem_addr(MEM_ADDR), .word_in(WORD),
    .fault(FAULT), .slow(SLOW), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA), .tlb_miss(MISS), .tlb_prot(PROT),
    .seen_addr(SEEN));
  always #50 CORE_CLK = ~CORE_CLK;
  function automatic logic [31:0] lfsr();
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h04C11DB7 : 32'h0);
    return lfsr_q;
  endfunction
  function automatic logic [31:0] rd(input int i);
    case (i)
      1: return STATUS_WORD;   2: return GLOBAL_BASE;  3: return VECTOR_BASE; 4: return SAVED_STATUS;
      5: return SAVED_PC;      6: return DEBUG_BASE;   8: return FLOAT_XFER;  9: return FLOAT_CTL;
      10: return ACCUM_HIGH;   11: return ACCUM_LOW;   12: return RETURN_LINK;
      default: return 32'h0;
    endcase
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one instruction: t is the target, usr clears the mode bit of a status word load
  task automatic run(input int t, input bit mm, input bit slot, input bit bad, input logic [1:0] flt, input bit usr);
    logic [31:0] src, dat, val, pc, msk;
    logic [15:0] op;
    bit hit, priv;
    int n;
    logic ev;
    lcsr_pkg::lcsr_exc_t ee, ec;
    src = lfsr();
    dat = lfsr();
    pc = lfsr();
    if (mm) src = {src[31:2], bad, 1'b0};
    val = mm ? dat : src;
    if (t == 1) val[30] = !usr;
    if (mm) dat = val; else src = val;
    op = {4'h4, src[11:8], mm ? mlo[t] : rlo[t]};
    if (t == 7) op[6:4] = src[6:4];
    priv = (t == 1) || (t >= 3 && t <= 7);
    msk = (t == 1) ? 32'h700083F3 : (t == 9) ? 32'h003FFFFF : 32'hFFFFFFFF;
    ee = lcsr_pkg::LCSR_EXC_NONE;
    if (priv && slot) ee = lcsr_pkg::LCSR_EXC_SLOT;
    else if (priv && !exp_reg[1][30]) ee = lcsr_pkg::LCSR_EXC_ILLEGAL;
    else if (mm && bad) ee = lcsr_pkg::LCSR_EXC_ADDR;
    else if (mm && flt == 2'h1) ee = lcsr_pkg::LCSR_EXC_TLB_MISS;
    else if (mm && flt == 2'h2) ee = lcsr_pkg::LCSR_EXC_TLB_PROT;
    @(posedge CORE_CLK);
    ISSUE_VALID <= 1'b1;
    OPCODE <= op;
    SRC_GENERAL_REG <= src;
    IN_DELAY_SLOT <= slot;
    WORD <= dat;
    PC_IN <= pc;
    FAULT <= flt;
    SLOW <= dat[3];
    @(negedge CORE_CLK);
    n = 0;
    hit = (EXC_VALID === 1'b1);
    ev = EXC_VALID;
    ec = EXC_CODE;
    `CHK("issue", {1'b1, op[11:8]}, {ISSUE_READY, SRC_INDEX})
    @(posedge CORE_CLK);
    ISSUE_VALID <= 1'b0;
    while (!hit && n < 40) begin
      @(negedge CORE_CLK);
      n++;
      hit = (DONE === 1'b1) || (EXC_VALID === 1'b1);
      ev = EXC_VALID;
      ec = EXC_CODE;
    end
    // exception seen at the falling edge, never in the time step of the launching edge
    `CHK("exception", ee != lcsr_pkg::LCSR_EXC_NONE, ev)
    if (ee != lcsr_pkg::LCSR_EXC_NONE) `CHK("code", ee, ec)
    else begin
      `CHK("pc", {1'b1, mm, t == 7, pc + 32'h2}, {PC_WE, RM_WE, SHADOW_WE, PC_NEXT})
      if (!mm) `CHK("states", (t == 1) ? 4 : (t == 2) ? 3 : (t == 12) ? 2 : 1, n)
      if (mm) `CHK("increment", {RM_WE, src + 32'h4, src}, {RM_WE, RM_WDATA, SEEN})
      if (t == 7) `CHK("shadow", {SHADOW_WE, src[6:4], ~exp_reg[1][29], val}, {SHADOW_WE, SHADOW_IDX, SHADOW_BANK, SHADOW_WDATA})
      if (t != 7) exp_reg[t] = val & msk;
    end
    @(negedge CORE_CLK);
    for (int i = 1; i < 13; i++)
      if (i != 7) `CHK("register", exp_reg[i], rd(i))
  endtask
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    foreach (exp_reg[i]) exp_reg[i] = 32'h0;
    exp_reg[1] = 32'h700000F0;
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    for (int k = 0; k < 4; k++)
      for (int t = 1; t < 13; t++) run(t, k[0], 1'b0, 1'b0, 2'h0, 1'b0);
    $display("test all targets done");
    run(3, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0);
    run(2, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
    run(9, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0);
    run(10, 1'b1, 1'b0, 1'b0, 2'h1, 1'b0);
    run(4, 1'b1, 1'b0, 1'b0, 2'h1, 1'b0);
    run(12, 1'b1, 1'b0, 1'b0, 2'h2, 1'b0);
    $display("test faults done");
    run(1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1);
    for (int t = 1; t < 8; t++) run(t, t[0], 1'b0, 1'b0, 2'h0, 1'b1);
    run(5, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1);
    run(11, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1);
    $display("test user mode done");
    // frozen core: a privileged load offered in user mode raises nothing
    @(posedge CORE_CLK);
    CLK_EN <= 1'b0;
    ISSUE_VALID <= 1'b1;
    OPCODE <= 16'h412E;
    repeat (3) begin
      @(negedge CORE_CLK);
      `CHK("frozen", 2'b00, {EXC_VALID, DONE})
    end
    @(posedge CORE_CLK);
    CLK_EN <= 1'b1;
    ISSUE_VALID <= 1'b0;
    run(2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1);
    $display("test clock enable done");
    report_and_stop();
  end
endmodule // test_control_system_register_loads
